// ===== common/break_trigger_pkg.sv
package break_trigger_pkg;

	// line timing, in bit periods and clock cycles
	localparam int unsigned   DEF_BIT_CYCLES      = 6510;  // about 19.2 kbit/s at 125 MHz
	localparam int unsigned   DEF_BREAK_SEND_BITS = 13;
	localparam int unsigned   DEF_BREAK_MIN_BITS  = 11;
	localparam int unsigned   DELIMITER_BITS      = 1;
	localparam int unsigned   BIT_CNT_W           = 16;
	localparam int unsigned   LEN_CNT_W           = 8;

	// values after reset
	localparam logic          RST_TRIGGER         = 1'b0;
	localparam logic          RST_STATUS_FLAG     = 1'b0;
	localparam logic          RST_LINE_LEVEL      = 1'b1;
	localparam logic [2:0]    RST_SYNC            = 3'h7;

	typedef enum logic [1:0]
	{
		RX_OFF,
		RX_HUNT,
		RX_LOW
	} rx_state_t;

	typedef enum logic [1:0]
	{
		TX_IDLE,
		TX_LOW,
		TX_DELIM
	} tx_state_t;

endpackage : break_trigger_pkg

// ===== logic/lin_sync_break_trigger.sv
`timescale 1ns/10ps
module lin_sync_break_trigger
#(
	parameter int unsigned BIT_CYCLES      = break_trigger_pkg::DEF_BIT_CYCLES,      // clocks per bit
	parameter int unsigned BREAK_SEND_BITS = break_trigger_pkg::DEF_BREAK_SEND_BITS, // low bits sent
	parameter int unsigned BREAK_MIN_BITS  = break_trigger_pkg::DEF_BREAK_MIN_BITS   // low bits a break must exceed: exactly this many bit times is rejected
)
(
	input  wire logic clk,                           // 125 MHz clock
	input  wire logic rst,                           // synchronous reset, active high
	input  wire logic unit_power_on,                 // mode register power bit
	input  wire logic transmit_enable_bit,           // mode register transmit enable
	input  wire logic receive_enable_bit,            // mode register receive enable
	input  wire logic ctl_write,                     // one-cycle write strobe of the control register
	input  wire logic wr_break_receive_trigger,      // written receive trigger value
	input  wire logic wr_break_send_trigger,         // written send trigger value
	input  wire logic status_flag_clear,             // one-cycle clear of the receive status flag
	input  wire logic rxd,                           // serial line input pin
	output logic      txd,                           // serial line output pin
	output logic      rd_break_receive_trigger,      // read value of receive trigger
	output logic      rd_break_send_trigger,         // read value of send trigger
	output logic      break_receive_status_flag,     // set on a good break, held on error
	output logic      break_rx_busy,                 // receive trigger state is armed
	output logic      break_tx_busy,                 // send trigger state is active
	output logic      intr_break_received,           // one-cycle pulse: break reception complete
	output logic      intr_break_sent                // one-cycle pulse: break transmission complete
);
	import break_trigger_pkg::*;

	// refused at elaboration: settings below the minimums, or too large for the bit and length counters to hold
	if (BIT_CYCLES < 2 || BIT_CYCLES >= (1 << BIT_CNT_W))
	begin
		$error("BIT_CYCLES out of range");
	end
	if (BREAK_SEND_BITS < 1 || BREAK_SEND_BITS >= (1 << LEN_CNT_W))
	begin
		$error("BREAK_SEND_BITS out of range");
	end
	if (BREAK_MIN_BITS < 1 || BREAK_MIN_BITS >= (1 << LEN_CNT_W) - 1)
	begin
		$error("BREAK_MIN_BITS out of range");
	end

	localparam logic [BIT_CNT_W-1:0] BIT_LAST  = BIT_CNT_W'(BIT_CYCLES - 1);
	localparam logic [LEN_CNT_W-1:0] SEND_LAST = LEN_CNT_W'(BREAK_SEND_BITS - 1);
	localparam logic [LEN_CNT_W-1:0] DELIM_LAST = LEN_CNT_W'(DELIMITER_BITS - 1);
	localparam logic [LEN_CNT_W-1:0] MIN_LOW   = LEN_CNT_W'(BREAK_MIN_BITS);
	localparam logic [LEN_CNT_W-1:0] LEN_MAX   = {LEN_CNT_W{1'b1}};

	typedef struct packed
	{
		logic [2:0]           rx_sync;
		logic                 rx_level;
		rx_state_t            rx_state;
		logic [BIT_CNT_W-1:0] rx_div;
		logic [LEN_CNT_W-1:0] rx_len;
		tx_state_t            tx_state;
		logic [BIT_CNT_W-1:0] tx_div;
		logic [LEN_CNT_W-1:0] tx_len;
		logic                 rx_trig;
		logic                 tx_trig;
		logic                 status_flag;
		logic                 irq_rx;
		logic                 irq_tx;
		logic                 txd;
		logic                 rd_rx_trig;
		logic                 rd_tx_trig;
	} state_t;

	state_t cur;
	state_t next_cur;

	logic rx_allowed;
	logic tx_allowed;
	logic rx_tick;
	logic tx_tick;

	assign rx_allowed = unit_power_on & receive_enable_bit;
	assign tx_allowed = unit_power_on & transmit_enable_bit;
	assign rx_tick    = (cur.rx_div == BIT_LAST);
	assign tx_tick    = (cur.tx_div == BIT_LAST);

	always_comb
	begin
		next_cur = cur;
		next_cur.irq_rx = 1'b0;
		next_cur.irq_tx = 1'b0;
		// trigger bits never read back as one
		next_cur.rd_rx_trig = 1'b0;
		next_cur.rd_tx_trig = 1'b0;

		// first stage feeds only the second; level moves once stages two and three agree
		next_cur.rx_sync = {cur.rx_sync[1:0], rxd};
		if (cur.rx_sync[1] == cur.rx_sync[2])
			next_cur.rx_level = cur.rx_sync[2];

		if (status_flag_clear)
			next_cur.status_flag = 1'b0;

		// receive side: a zero write is ignored, so a stray clear cannot abort an armed hunt
		if (ctl_write && wr_break_receive_trigger && rx_allowed && !cur.rx_trig)
		begin
			next_cur.rx_trig  = 1'b1;
			next_cur.rx_state = RX_HUNT;
		end

		unique case (cur.rx_state)
			RX_OFF:
			begin
				next_cur.rx_len = '0;
			end
			RX_HUNT:
			begin
				next_cur.rx_len = '0;
				if (!cur.rx_level)
				begin
					next_cur.rx_state = RX_LOW;
					next_cur.rx_div   = '0;
				end
			end
			RX_LOW:
			begin
				next_cur.rx_div = rx_tick ? '0 : cur.rx_div + 1'b1;
				if (rx_tick && cur.rx_len != LEN_MAX)
					next_cur.rx_len = cur.rx_len + 1'b1;
				if (cur.rx_level)
				begin
					if (cur.rx_len >= MIN_LOW)
					begin
						next_cur.rx_state    = RX_OFF;
						next_cur.rx_trig     = 1'b0;
						next_cur.irq_rx      = 1'b1;
						next_cur.status_flag = 1'b1;
					end
					else
					begin
						// too short: hunt again, flag left as it stands
						next_cur.rx_state = RX_HUNT;
					end
				end
			end
		endcase

		// transmit side
		if (ctl_write && wr_break_send_trigger && tx_allowed && !cur.tx_trig)
		begin
			next_cur.tx_trig  = 1'b1;
			next_cur.tx_state = TX_LOW;
			next_cur.tx_div   = '0;
			next_cur.tx_len   = '0;
			next_cur.txd      = 1'b0;
		end
		else
		begin
			unique case (cur.tx_state)
				TX_IDLE:
				begin
					next_cur.txd = RST_LINE_LEVEL;
				end
				TX_LOW:
				begin
					next_cur.tx_div = tx_tick ? '0 : cur.tx_div + 1'b1;
					if (tx_tick)
					begin
						next_cur.tx_len = cur.tx_len + 1'b1;
						if (cur.tx_len == SEND_LAST)
						begin
							next_cur.tx_state = TX_DELIM;
							next_cur.tx_len   = '0;
							next_cur.txd      = 1'b1;
						end
					end
				end
				TX_DELIM:
				begin
					next_cur.tx_div = tx_tick ? '0 : cur.tx_div + 1'b1;
					if (tx_tick)
					begin
						next_cur.tx_len = cur.tx_len + 1'b1;
						if (cur.tx_len == DELIM_LAST)
						begin
							next_cur.tx_state = TX_IDLE;
							next_cur.tx_trig  = 1'b0;
							next_cur.irq_tx   = 1'b1;
						end
					end
				end
			endcase
		end

		// dropping power or enable abandons the operation without an interrupt
		if (!rx_allowed)
		begin
			next_cur.rx_state = RX_OFF;
			next_cur.rx_trig  = 1'b0;
			next_cur.irq_rx   = 1'b0;
		end
		if (!tx_allowed)
		begin
			next_cur.tx_state = TX_IDLE;
			next_cur.tx_trig  = 1'b0;
			next_cur.txd      = RST_LINE_LEVEL;
			next_cur.irq_tx   = 1'b0;
		end

		// a good break in the same cycle as a clear keeps the flag set
		if (next_cur.irq_rx)
			next_cur.status_flag = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cur             <= '0;
			cur.rx_sync     <= RST_SYNC;
			cur.rx_level    <= RST_LINE_LEVEL;
			cur.rx_state    <= RX_OFF;
			cur.tx_state    <= TX_IDLE;
			cur.rx_trig     <= RST_TRIGGER;
			cur.tx_trig     <= RST_TRIGGER;
			cur.status_flag <= RST_STATUS_FLAG;
			cur.txd         <= RST_LINE_LEVEL;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign txd                       = cur.txd;
	assign rd_break_receive_trigger  = cur.rd_rx_trig;
	assign rd_break_send_trigger     = cur.rd_tx_trig;
	assign break_receive_status_flag = cur.status_flag;
	assign break_rx_busy             = cur.rx_trig;
	assign break_tx_busy             = cur.tx_trig;
	assign intr_break_received       = cur.irq_rx;
	assign intr_break_sent           = cur.irq_tx;

endmodule : lin_sync_break_trigger

// ===== tb/lin_sync_break_trigger_assertions.sv
`timescale 1ns/10ps
module break_trigger_chk
#(
	parameter int unsigned BIT_CYCLES      = 8,
	parameter int unsigned BREAK_SEND_BITS = 4
)
(
	input wire logic clk,                        // block clock
	input wire logic rst,                        // synchronous reset, active high
	input wire logic unit_power_on,              // power bit
	input wire logic transmit_enable_bit,        // transmit enable
	input wire logic receive_enable_bit,         // receive enable
	input wire logic ctl_write,                  // control write strobe
	input wire logic wr_break_receive_trigger,   // written receive trigger
	input wire logic wr_break_send_trigger,      // written send trigger
	input wire logic status_flag_clear,          // flag clear strobe
	input wire logic txd,                        // line output
	input wire logic rd_break_receive_trigger,   // receive trigger read value
	input wire logic rd_break_send_trigger,      // send trigger read value
	input wire logic break_receive_status_flag,  // receive status flag
	input wire logic break_rx_busy,              // receive armed
	input wire logic break_tx_busy,              // send active
	input wire logic intr_break_received,        // receive done pulse
	input wire logic intr_break_sent             // send done pulse
);
	logic [15:0] low_cnt;
	logic [15:0] high_cnt;
	// run lengths of the line level, so break and delimiter lengths are checked exactly
	always_ff @(posedge clk)
	begin
		low_cnt  <= (rst || txd) ? 16'h0000 : low_cnt + 16'h0001;
		high_cnt <= (rst || !txd) ? 16'h0000 : high_cnt + 16'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence rx_arm;
		ctl_write && wr_break_receive_trigger && !break_rx_busy;
	endsequence
	sequence tx_arm;
		ctl_write && wr_break_send_trigger && unit_power_on && transmit_enable_bit && !break_tx_busy;
	endsequence
	chk_rx_read_zero: assert property (rd_break_receive_trigger == 1'h0)
		else $error("receive trigger read back not zero");
	chk_tx_read_zero: assert property (rd_break_send_trigger == 1'h0)
		else $error("send trigger read back not zero");
	chk_rx_arm_taken: assert property ((rx_arm ##0 (unit_power_on && receive_enable_bit)) |=> break_rx_busy)
		else $error("receive arm not taken");
	chk_rx_arm_refused: assert property ((rx_arm ##0 !receive_enable_bit) |=> !break_rx_busy)
		else $error("receive arm taken while disabled");
	chk_tx_start: assert property (tx_arm |=> break_tx_busy && !txd)
		else $error("break send did not start");
	chk_tx_low_len: assert property ($rose(txd) && break_tx_busy |-> low_cnt == BREAK_SEND_BITS * BIT_CYCLES)
		else $error("break low length wrong");
	chk_tx_end: assert property (intr_break_sent |-> !break_tx_busy && $past(break_tx_busy)
		&& high_cnt == BIT_CYCLES)
		else $error("send completion wrong");
	chk_rx_end: assert property (intr_break_received |-> !break_rx_busy && break_receive_status_flag)
		else $error("receive completion wrong");
	chk_flag_cause: assert property ($rose(break_receive_status_flag) |-> intr_break_received)
		else $error("status flag set without completion");
	chk_flag_held: assert property (break_receive_status_flag && !status_flag_clear |=> break_receive_status_flag)
		else $error("status flag dropped");
	chk_rx_pulse_once: assert property (intr_break_received |=> !intr_break_received)
		else $error("receive interrupt longer than one cycle");
endmodule : break_trigger_chk
bind lin_sync_break_trigger break_trigger_chk #(.BIT_CYCLES(BIT_CYCLES), .BREAK_SEND_BITS(BREAK_SEND_BITS)) i_chk (.*);

// ===== tb/lin_node_model.sv
`timescale 1ns/10ps
module lin_node_model
#(
	parameter int unsigned BIT_CYCLES = 8
)
(
	input  wire logic       clk,        // bench clock
	input  wire logic       send,       // start a low field
	input  wire logic [7:0] low_bits,   // low field length in bits
	input  wire logic       txd,        // line from the device
	output logic            rxd,        // line to the device
	output logic [15:0]     tx_low_len  // last low run seen on txd
);
	logic [15:0] run = 16'h0000;
	int          left = 0;
	initial tx_low_len = 16'h0000;
	// the line is pulled up, so released means high
	always @(posedge clk)
	begin
		run <= txd ? 16'h0000 : run + 16'h0001;
		if (txd && run != 16'h0000)
			tx_low_len <= run;
		if (send)
			left = low_bits * BIT_CYCLES;
		else if (left > 0)
			left = left - 1;
		rxd <= (left == 0);
	end
endmodule : lin_node_model

// ===== tb/test_lin_sync_break_trigger.sv
`timescale 1ns/10ps
module test_lin_sync_break_trigger;
	localparam int unsigned BC = 8;
	localparam int unsigned SB = 4;
	localparam int unsigned MB = 3;
	logic clk = 1'h0, rst = 1'h1, unit_power_on = 1'h0, transmit_enable_bit = 1'h0, receive_enable_bit = 1'h0;
	logic ctl_write = 1'h0, wr_break_receive_trigger = 1'h0, wr_break_send_trigger = 1'h0;
	logic status_flag_clear = 1'h0, send = 1'h0, rxd, txd, rd_break_receive_trigger, rd_break_send_trigger;
	logic break_receive_status_flag, break_rx_busy, break_tx_busy, intr_break_received, intr_break_sent;
	logic [7:0]  low_bits = 8'h00;
	logic [15:0] tx_low_len;
	int          mismatches = 0, check_count = 0;
	always #4 clk = ~clk;
	lin_sync_break_trigger #(.BIT_CYCLES(BC), .BREAK_SEND_BITS(SB), .BREAK_MIN_BITS(MB)) i_dut (.*);
	lin_node_model #(.BIT_CYCLES(BC)) i_node (.*);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic ctl(input logic r, input logic t);
		ctl_write = 1'h1;
		wr_break_receive_trigger = r;
		wr_break_send_trigger = t;
		step(1);
		ctl_write = 1'h0;
	endtask : ctl
	task automatic wait_intr(input logic tx);
		for (int i = 0; i < 1000; i++)
		begin
			if ((tx ? intr_break_sent : intr_break_received) === 1'h1)
				return;
			step(1);
		end
		mismatches++;
		give_verdict();
	endtask : wait_intr
	task automatic line_low(input logic [7:0] bits, input logic good);
		low_bits = bits;
		send = 1'h1;
		step(1);
		send = 1'h0;
		if (good)
			wait_intr(1'h0);
		else
			step(int'(bits) * BC + 16);
	endtask : line_low
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial
	begin
		step(5);
		rst = 1'h0;
		check(txd, 16'h0001);
		unit_power_on = 1'h1;
		ctl(1'h0, 1'h1);
		step(1);
		check(break_tx_busy, 16'h0000);
		transmit_enable_bit = 1'h1;
		ctl(1'h0, 1'h1);
		check(break_tx_busy, 16'h0001);
		check(rd_break_send_trigger, 16'h0000);
		wait_intr(1'h1);
		check(break_tx_busy, 16'h0000);
		check(tx_low_len, 16'(SB * BC));
		ctl(1'h1, 1'h0);
		step(1);
		check(break_rx_busy, 16'h0000);
		receive_enable_bit = 1'h1;
		ctl(1'h1, 1'h0);
		check(break_rx_busy, 16'h0001);
		line_low(8'(MB - 1), 1'h0);
		check(break_rx_busy, 16'h0001);
		check(break_receive_status_flag, 16'h0000);
		line_low(8'(MB + 1), 1'h1);
		check(break_receive_status_flag, 16'h0001);
		check(break_rx_busy, 16'h0000);
		check(rd_break_receive_trigger, 16'h0000);
		step(1);
		ctl(1'h1, 1'h0);
		line_low(8'(MB - 1), 1'h0);
		check(break_receive_status_flag, 16'h0001);
		status_flag_clear = 1'h1;
		step(1);
		status_flag_clear = 1'h0;
		check(break_receive_status_flag, 16'h0000);
		receive_enable_bit = 1'h0;
		step(2);
		check(break_rx_busy, 16'h0000);
		give_verdict();
	end
endmodule : test_lin_sync_break_trigger
